// ---- pkg/crt_timing_regs.vh ----
// Purpose: register offsets, fields and reset values of the raster timer
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   all timing positions are 12 bits in the low bits of a word
`ifndef CRT_TIMING_REGS_VH
`define CRT_TIMING_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CRT_OFS_HCNT      8'h04
`define CRT_OFS_HLEN      8'h08
`define CRT_OFS_HSYNC     8'h0c
`define CRT_OFS_HBRISE    8'h10
`define CRT_OFS_HBFALL    8'h14
`define CRT_OFS_HPRE      8'h18
`define CRT_OFS_VCNT      8'h1c
`define CRT_OFS_VLEN      8'h20
`define CRT_OFS_VSYNC     8'h24
`define CRT_OFS_VBRISE    8'h28
`define CRT_OFS_VBFALL    8'h2c
`define CRT_OFS_VPRE      8'h30
`define CRT_OFS_CTL       8'h38
`define CRT_OFS_CTL2      8'h40
`define CRT_OFS_TAP       8'h44

// ****************************************************************
// Fields of repaint_control_main
// ****************************************************************
`define CRT_CTL_TAPSEL_LO 0
`define CRT_CTL_BUF       3
`define CRT_CTL_HBRELOAD  4
`define CRT_CTL_VIDEN     5
`define CRT_CTL_INT_HS    7
`define CRT_CTL_INT_VS    8
`define CRT_CTL_MASK      12'h7bf

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define CRT_W             12
`define CRT_RST_CTL       12'h180
`define CRT_RST_POS       12'h000
`define CRT_RST_HLEN      12'h3ff
`define CRT_RST_VLEN      12'h20c
`define CRT_RESP_OKAY     2'b00
`define CRT_RESP_SLVERR   2'b10

`endif

// ---- hdl/crt_tap_counter.v ----
// Purpose: serial-memory tap counter that mirrors the half select
// Assumes: one character clock per increment
// Notes:   load request is raised when the counter reaches the tap
`timescale 1ns/1ps
`include "crt_timing_regs.vh"

module crt_tap_counter (
   input  wire                 mclk,
   input  wire                 rst_n,
   input  wire                 read_xfer,
   input  wire [2:0]           tap_sel,
   output wire [`CRT_W-1:0]    tap_count,
   output wire                 half_select,
   output reg                  sr_load_q
);

   reg  [`CRT_W-1:0] cnt_q;
   wire [`CRT_W-1:0] cnt_inc = cnt_q + 12'h001;

   // ****************************************************************
   // Counter: cleared by a read transfer, else counts
   // ****************************************************************
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= 12'h000;
         sr_load_q <= 1'b0;
      end else begin
         if (read_xfer) begin
            cnt_q <= 12'h000;
         end else begin
            cnt_q <= cnt_q + 12'h001;
         end
         // Load pulse once the selected tap bit first goes high
         // Only a true 0-to-1 step of the tap bit may fire a load
         sr_load_q <= !read_xfer && !cnt_q[tap_sel] &&
                      cnt_inc[tap_sel] && !sr_load_q;
      end
   end

   // Selected tap bit tracks which serial half is shifting out
   assign half_select = cnt_q[tap_sel];
   assign tap_count   = cnt_q;

endmodule

// ---- hdl/crt_timing_top.v ----
// Purpose: raster timing counters with AXI4-Lite register access
// Assumes: mclk is the character clock, inputs synchronous to it
// Notes:   external syncs are active-low levels; edges are detected
//
// Behaviour
// - Horizontal blank ends when the pixel counter meets the blank fall position.
// - External horizontal or vertical sync, or the line wrap under internal horizontal sync, preloads the pixel counter.
// - Line counter advances on every horizontal sync and is readable.
// - Line counter wraps when it matches the frame length.
// - Vertical sync asserts at the programmed sync line.
// - Vertical blank starts at the programmed rise line.
// - Vertical blank ends at the programmed fall line.
// - External vertical sync, or the frame wrap under internal vertical sync, preloads the line counter.
// - Tap counter clears after read transfer, counts each character clock.
// - Tap counter mirrors half select and schedules shift register loads.
// - Pixel counter increments every character clock and is readable.
// - Pixel counter wraps when it matches the line length.
// - Horizontal sync asserts at the programmed sync position.
// - Horizontal blank starts at the programmed rise position.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "crt_timing_regs.vh"

module crt_timing_top (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ext_hsync_n,
   input  wire        ext_vsync_n,
   input  wire        read_xfer,
   output reg         hsync_n,
   output reg         vsync_n,
   output reg         blank_n,
   output reg         vertical_blank_n,
   output reg         display_buffer,
   output wire        vram_half_select,
   output wire        sr_load
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [11:0] hcnt_q, hlen_q, hsync_q, hbrise_q, hbfall_q, hpre_q;
   reg [11:0] vcnt_q, vlen_q, vsync_q, vbrise_q, vbfall_q, vpre_q;
   reg [11:0] ctl_q;
   reg [31:0] ctl2_q;
   reg        hblank_q, vblank_q;
   reg        ext_hs_d_q, ext_vs_d_q;
   reg        aw_got_q, w_got_q;
   reg [7:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   wire [11:0] tap_count;

   // ****************************************************************
   // AXI4-Lite write: address and data taken in either order
   // ****************************************************************
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
   wire aw_now = aw_got_q || s_axi_awvalid;
   wire w_now  = w_got_q || s_axi_wvalid;
   wire do_wr  = aw_now && w_now && !s_axi_bvalid;
   wire [7:0]  wa = aw_got_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
   wire [3:0]  ws = w_got_q ? wstrb_q : s_axi_wstrb;
   // Except in CTL2, only the low 12 bits are held, so byte lanes 0 and 1 matter
   wire [11:0] wmask = {{4{ws[1]}}, {8{ws[0]}}};

   function [11:0] merge;
      input [11:0] old;
      input [31:0] d;
      input [11:0] m;
      begin
         merge = (old & ~m) | (d[11:0] & m);
      end
   endfunction

   function wr_known;
      input [7:0] a;
      begin
         case (a)
            `CRT_OFS_HLEN, `CRT_OFS_HSYNC, `CRT_OFS_HBRISE,
            `CRT_OFS_HBFALL, `CRT_OFS_HPRE, `CRT_OFS_VLEN,
            `CRT_OFS_VSYNC, `CRT_OFS_VBRISE, `CRT_OFS_VBFALL,
            `CRT_OFS_VPRE, `CRT_OFS_CTL, `CRT_OFS_CTL2: wr_known = 1'b1;
            default: wr_known = 1'b0;
         endcase
      end
   endfunction

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_q     <= 1'b0;
         w_got_q      <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CRT_RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_wr) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known(wa) ? `CRT_RESP_OKAY
                                          : `CRT_RESP_SLVERR;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_got_q <= 1'b1;
               awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_got_q <= 1'b1;
               wdata_q <= s_axi_wdata;
               wstrb_q <= s_axi_wstrb;
            end
         end
      end
   end

   // ****************************************************************
   // Host-written timing registers
   // ****************************************************************
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hlen_q   <= `CRT_RST_HLEN;
         hsync_q  <= `CRT_RST_POS;
         hbrise_q <= `CRT_RST_POS;
         hbfall_q <= `CRT_RST_POS;
         hpre_q   <= `CRT_RST_POS;
         vlen_q   <= `CRT_RST_VLEN;
         vsync_q  <= `CRT_RST_POS;
         vbrise_q <= `CRT_RST_POS;
         vbfall_q <= `CRT_RST_POS;
         vpre_q   <= `CRT_RST_POS;
         ctl_q    <= `CRT_RST_CTL;
         ctl2_q   <= 32'h0000_0000;
      end else if (do_wr) begin
         case (wa)
            `CRT_OFS_HLEN:   hlen_q   <= merge(hlen_q, wd, wmask);
            `CRT_OFS_HSYNC:  hsync_q  <= merge(hsync_q, wd, wmask);
            `CRT_OFS_HBRISE: hbrise_q <= merge(hbrise_q, wd, wmask);
            `CRT_OFS_HBFALL: hbfall_q <= merge(hbfall_q, wd, wmask);
            `CRT_OFS_HPRE:   hpre_q   <= merge(hpre_q, wd, wmask);
            `CRT_OFS_VLEN:   vlen_q   <= merge(vlen_q, wd, wmask);
            `CRT_OFS_VSYNC:  vsync_q  <= merge(vsync_q, wd, wmask);
            `CRT_OFS_VBRISE: vbrise_q <= merge(vbrise_q, wd, wmask);
            `CRT_OFS_VBFALL: vbfall_q <= merge(vbfall_q, wd, wmask);
            `CRT_OFS_VPRE:   vpre_q   <= merge(vpre_q, wd, wmask);
            `CRT_OFS_CTL:
               ctl_q <= merge(ctl_q, wd, wmask) & `CRT_CTL_MASK;
            `CRT_OFS_CTL2: begin
               ctl2_q[7:0]  <= ws[0] ? wd[7:0] : ctl2_q[7:0];
               ctl2_q[15:8] <= ws[1] ? wd[15:8] : ctl2_q[15:8];
               ctl2_q[23:16] <= ws[2] ? wd[23:16] : ctl2_q[23:16];
               ctl2_q[31:24] <= ws[3] ? wd[31:24] : ctl2_q[31:24];
            end
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Sync sources and counters
   // ****************************************************************
   wire int_hs_sel = ctl_q[`CRT_CTL_INT_HS];
   wire int_vs_sel = ctl_q[`CRT_CTL_INT_VS];
   wire h_wrap     = (hcnt_q == hlen_q);
   // Internal syncs fire at the programmed positions
   wire int_hs     = (hcnt_q == hsync_q);
   wire int_vs     = int_hs && (vcnt_q == vsync_q);
   // Falling edges of the active-low external syncs
   wire ext_hs     = ext_hs_d_q && !ext_hsync_n;
   wire ext_vs     = ext_vs_d_q && !ext_vsync_n;
   wire hs_evt     = int_hs_sel ? int_hs : ext_hs;
   wire v_wrap     = (vcnt_q == vlen_q);
   // Internal syncs preload at the wrap, so a zero preload cannot stall
   wire h_load     = (int_hs_sel ? h_wrap : ext_hs) ||
                     (!int_vs_sel && ext_vs);
   wire v_load     = int_vs_sel ? (hs_evt && v_wrap) : ext_vs;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hcnt_q     <= 12'h000;
         vcnt_q     <= 12'h000;
         ext_hs_d_q <= 1'b1;
         ext_vs_d_q <= 1'b1;
      end else begin
         ext_hs_d_q <= ext_hsync_n;
         ext_vs_d_q <= ext_vsync_n;
         // Preload on sync beats the free-running count
         if (h_load) begin
            hcnt_q <= hpre_q;
         end else if (h_wrap) begin
            hcnt_q <= 12'h000;
         end else begin
            hcnt_q <= hcnt_q + 12'h001;
         end
         if (v_load) begin
            vcnt_q <= vpre_q;
         end else if (hs_evt) begin
            vcnt_q <= v_wrap ? 12'h000 : vcnt_q + 12'h001;
         end
      end
   end

   // ****************************************************************
   // Sync, blank and buffer select outputs
   // ****************************************************************
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hblank_q         <= 1'b1;
         vblank_q         <= 1'b1;
         hsync_n          <= 1'b1;
         vsync_n          <= 1'b1;
         blank_n          <= 1'b0;
         vertical_blank_n <= 1'b0;
         display_buffer   <= 1'b0;
      end else begin
         if (hcnt_q == hbrise_q) begin
            hblank_q <= 1'b1;
         end else if (hcnt_q == hbfall_q) begin
            hblank_q <= 1'b0;
         end
         if (hs_evt && vcnt_q == vbrise_q) begin
            vblank_q <= 1'b1;
         end else if (hs_evt && vcnt_q == vbfall_q) begin
            vblank_q <= 1'b0;
         end
         // Sync is a one-character pulse at the sync position
         hsync_n          <= !int_hs;
         // Vertical sync falls on the sync line, rises on the next line
         if (int_vs_sel && int_vs) begin
            vsync_n <= 1'b0;
         end else if (int_vs_sel && hs_evt) begin
            vsync_n <= 1'b1;
         end
         vertical_blank_n <= !vblank_q;
         blank_n <= !(hblank_q || vblank_q || !ctl_q[`CRT_CTL_VIDEN]);
         // Buffer swap waits for vertical blank so no frame tears
         if (vblank_q && vertical_blank_n) begin
            display_buffer <= ctl_q[`CRT_CTL_BUF];
         end
      end
   end

   // ****************************************************************
   // Serial memory tap counter
   // ****************************************************************
   crt_tap_counter u_tap (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .read_xfer   (read_xfer),
      .tap_sel     (ctl_q[2:0]),
      .tap_count   (tap_count),
      .half_select (vram_half_select),
      .sr_load_q   (sr_load)
   );

   // ****************************************************************
   // AXI4-Lite read: one cycle from address to data
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `CRT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CRT_RESP_OKAY;
         case (s_axi_araddr)
            `CRT_OFS_HCNT:   s_axi_rdata <= {20'h00000, hcnt_q};
            `CRT_OFS_HLEN:   s_axi_rdata <= {20'h00000, hlen_q};
            `CRT_OFS_HSYNC:  s_axi_rdata <= {20'h00000, hsync_q};
            `CRT_OFS_HBRISE: s_axi_rdata <= {20'h00000, hbrise_q};
            `CRT_OFS_HBFALL: s_axi_rdata <= {20'h00000, hbfall_q};
            `CRT_OFS_HPRE:   s_axi_rdata <= {20'h00000, hpre_q};
            `CRT_OFS_VCNT:   s_axi_rdata <= {20'h00000, vcnt_q};
            `CRT_OFS_VLEN:   s_axi_rdata <= {20'h00000, vlen_q};
            `CRT_OFS_VSYNC:  s_axi_rdata <= {20'h00000, vsync_q};
            `CRT_OFS_VBRISE: s_axi_rdata <= {20'h00000, vbrise_q};
            `CRT_OFS_VBFALL: s_axi_rdata <= {20'h00000, vbfall_q};
            `CRT_OFS_VPRE:   s_axi_rdata <= {20'h00000, vpre_q};
            `CRT_OFS_CTL:    s_axi_rdata <= {20'h00000, ctl_q};
            `CRT_OFS_CTL2:   s_axi_rdata <= ctl2_q;
            `CRT_OFS_TAP:    s_axi_rdata <= {20'h00000, tap_count};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `CRT_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- verif/crt_timing_asserts.sv ----
// Purpose: port-level checker for the raster timing block
// Assumes: single mclk domain, rst_n async active low
// Notes:   bound to crt_timing_top below the module
`timescale 1ns/1ps
module crt_timing_asserts (
   input logic        mclk,
   input logic        rst_n,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        hsync_n,
   input logic        vertical_blank_n,
   input logic        display_buffer,
   input logic        sr_load
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // Register bus handshakes
   // ****************************************************************
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response not held");
   property p_bans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
   endproperty
   a_bans: assert property (p_bans)
      else $error("write response late");
   property p_awblk;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_awblk: assert property (p_awblk)
      else $error("write taken while response pending");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data not held");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
   endproperty
   a_rans: assert property (p_rans)
      else $error("read answer late");
   // ****************************************************************
   // Raster and serial memory outputs
   // ****************************************************************
   // Internal sync is a single-cycle pulse
   property p_hpulse;
      $fell(hsync_n) |=> hsync_n;
   endproperty
   a_hpulse: assert property (p_hpulse)
      else $error("hsync pulse too wide");
   property p_srl;
      sr_load |=> !sr_load [*1];
   endproperty
   a_srl: assert property (p_srl)
      else $error("load pulse too wide");
   // Buffer swap only at the start of vertical blank
   property p_buf;
      $changed(display_buffer) |-> $fell(vertical_blank_n);
   endproperty
   a_buf: assert property (p_buf)
      else $error("buffer changed mid frame");
   c_wr:  cover property (s_axi_bvalid && s_axi_bready);
   c_srl: cover property (sr_load);
   c_vbl: cover property ($fell(vertical_blank_n));
endmodule

bind crt_timing_top crt_timing_asserts u_chk (
   .mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .hsync_n(hsync_n),
   .vertical_blank_n(vertical_blank_n),
   .display_buffer(display_buffer), .sr_load(sr_load));

// ---- verif/crt_far_model.sv ----
// Purpose: outside video source and serial memory port
// Assumes: syncs idle high, two-cycle low pulses
// Notes:   periods are free-running, so preload range checks stay loose
`timescale 1ns/1ps
module crt_far_model #(
   parameter int HPER = 16,
   parameter int VPER = 64,
   parameter int XPER = 36
) (
   input  logic mclk,
   input  logic rst_n,
   output logic ext_hsync_n,
   output logic ext_vsync_n,
   output logic read_xfer
);
   int hc, vc, xc;
   // Periodic syncs and read transfers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hc <= 0;
         vc <= 0;
         xc <= 0;
         ext_hsync_n <= 1'b1;
         ext_vsync_n <= 1'b1;
         read_xfer <= 1'b0;
      end else begin
         hc <= (hc == HPER - 1) ? 0 : hc + 1;
         vc <= (vc == VPER - 1) ? 0 : vc + 1;
         xc <= (xc == XPER - 1) ? 0 : xc + 1;
         ext_hsync_n <= !(hc < 2);
         ext_vsync_n <= !(vc < 2);
         read_xfer <= (xc == 0); // one-cycle transfer pulse
      end
   end
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the raster timing block
// Assumes: 40 MHz mclk, 10-line frame of 20-cycle lines
// Notes:   inputs move on posedge, outputs sampled on negedge
`timescale 1ns/1ps
`include "crt_timing_regs.vh"
module tb;
   logic mclk = 0, rst_n = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rd;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire ehs_n, evs_n, xfer, hs_n, vs_n, bl_n, vbl_n, dbuf, hsel, srl;
   int errors = 0, cmp_count = 0;
   initial forever #12.5 mclk = ~mclk;
   crt_timing_top DUT (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_hsync_n(ehs_n),
      .ext_vsync_n(evs_n), .read_xfer(xfer), .hsync_n(hs_n),
      .vsync_n(vs_n), .blank_n(bl_n), .vertical_blank_n(vbl_n),
      .display_buffer(dbuf), .vram_half_select(hsel), .sr_load(srl));
   crt_far_model u_far (.mclk(mclk), .rst_n(rst_n), .ext_hsync_n(ehs_n),
      .ext_vsync_n(evs_n), .read_xfer(xfer));
   // ****************************************************************
   // Bus tasks and comparison
   // ****************************************************************
   task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Readies sampled at negedge equal their value at the next posedge
   task automatic wr(input [7:0] a, input [31:0] d);
      bit aw, w, ta, tw;
      @(posedge mclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      aw = 1; w = 1;
      while (aw || w) begin
         @(negedge mclk); ta = awready; tw = wready;
         @(posedge mclk);
         if (aw && ta) begin awvalid <= 0; aw = 0; end
         if (w && tw) begin wvalid <= 0; w = 0; end
      end
      do @(negedge mclk); while (bvalid !== 1'b1);
      rs = bresp;
      @(posedge mclk); bready <= 0;
   endtask
   task automatic rdr(input [7:0] a);
      @(posedge mclk); araddr <= a; arvalid <= 1; rready <= 1;
      do @(negedge mclk); while (arready !== 1'b1);
      @(posedge mclk); arvalid <= 0;
      do @(negedge mclk); while (rvalid !== 1'b1);
      rd = rdata; rs = rresp;
      @(posedge mclk); rready <= 0;
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [7:0] ofs [10] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                              8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
      rdr(`CRT_OFS_CTL); chk("ctl reset", rd, 32'h180);
      rdr(`CRT_OFS_HLEN); chk("hlen reset", rd, 32'h3ff);
      rdr(`CRT_OFS_VLEN); chk("vlen reset", rd, 32'h20c);
      foreach (ofs[i]) begin
         wr(ofs[i], 32'hffff_fa5a); chk("rw resp", rs, 2'b00);
         rdr(ofs[i]); chk("rw value", rd, 32'ha5a);
      end
      wr(`CRT_OFS_CTL, 32'hffff_ffff); rdr(`CRT_OFS_CTL);
      chk("ctl mask", rd, 32'h7bf);
      // Low byte lane only: bits 11:8 keep their old value
      wstrb <= 4'h1;
      wr(`CRT_OFS_HLEN, 32'h0000_0f33);
      wstrb <= 4'hf;
      rdr(`CRT_OFS_HLEN);
      chk("byte lane", rd, 32'ha33);
      wr(`CRT_OFS_HCNT, 32'h5); chk("ro resp", rs, 2'b10);
      rdr(8'h3c); chk("unmapped resp", rs, 2'b10);
      chk("unmapped data", rd, 0);
   endtask
   task automatic t_frame;
      int nv, nb, nvb, nh;
      wr(`CRT_OFS_HLEN, 19); wr(`CRT_OFS_HSYNC, 0);
      wr(`CRT_OFS_HBRISE, 14); wr(`CRT_OFS_HBFALL, 18);
      wr(`CRT_OFS_VLEN, 9); wr(`CRT_OFS_VSYNC, 7);
      wr(`CRT_OFS_VBRISE, 6); wr(`CRT_OFS_VBFALL, 9);
      wr(`CRT_OFS_HPRE, 0); wr(`CRT_OFS_VPRE, 0);
      wr(`CRT_OFS_CTL, 32'h1a0);
      do @(negedge mclk); while (vs_n !== 1'b1);
      do @(negedge mclk); while (vs_n !== 1'b0);
      nv = 0; nb = 0; nvb = 0; nh = 0;
      repeat (200) begin
         nv += !vs_n; nvb += !vbl_n; nb += !bl_n; nh += !hs_n;
         @(negedge mclk);
      end
      chk("vsync low", nv, 20);
      chk("vblank low", nvb, 60);
      chk("blank low", nb, 88);
      chk("lines", nh, 10);
      chk("next frame", vs_n, 0);
   endtask
   task automatic t_buf;
      wr(`CRT_OFS_CTL, 32'h1a8); @(negedge mclk);
      chk("buffer held", dbuf, 0);
      do @(negedge mclk); while (vbl_n !== 1'b1);
      do @(negedge mclk); while (vbl_n !== 1'b0);
      chk("buffer swap", dbuf, 1);
   endtask
   task automatic t_ext;
      wr(`CRT_OFS_HLEN, 32'hfff); wr(`CRT_OFS_VLEN, 32'hfff);
      wr(`CRT_OFS_HPRE, 32'h100); wr(`CRT_OFS_VPRE, 3);
      wr(`CRT_OFS_CTL, 32'h020);
      repeat (300) @(posedge mclk);
      rdr(`CRT_OFS_HCNT);
      chk("hcnt preload", rd >= 32'h100 && rd <= 32'h118, 1);
      rdr(`CRT_OFS_VCNT);
      chk("vcnt preload", rd >= 3 && rd <= 8, 1);
   endtask
   task automatic t_tap;
      int np, nq;
      wr(`CRT_OFS_CTL, 32'h1a2);
      do @(negedge mclk); while (xfer !== 1'b1);
      np = 0; nq = 0;
      repeat (360) begin
         @(negedge mclk); np += srl; nq += hsel;
      end
      chk("load pulses", np, 40);
      chk("half select", nq, 160);
      rdr(`CRT_OFS_TAP); chk("tap range", rd < 36, 1);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      test_done;
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1;
      t_regs;
      t_frame;
      t_buf;
      t_ext;
      t_tap;
      test_done;
   end
endmodule
